// ### fms_formatter_model.sv
`timescale 1ns/1ns
`include "fms_params.svh"

module fms_formatter_model (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic [`FMS_OUT_N-1:0]  outbound_formatter_strobe,
  input  wire logic [`FMS_IN_N-1:0]   inbound_formatter_strobe,
  input  wire logic [`FMS_DB_W-1:0]   outbound_data,
  input  wire logic [`FMS_COND_N-1:0] status_level,
  output logic      [`FMS_DB_W-1:0]   inbound_data,
  output logic      [`FMS_COND_N-1:0] jump_condition_input
);
  logic [`FMS_DB_W-1:0] ctl_reg [`FMS_OUT_N];
  logic [`FMS_DB_W-1:0] noise;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers take the bus on their own outbound strobe
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < `FMS_OUT_N; i++)
      if (outbound_formatter_strobe[i])
        ctl_reg[i] <= outbound_data;
  end

  // Released bus wanders every cycle, so a stale value never holds for two cycles
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      noise <= 8'h5a;
    else
      noise <= noise + 8'h3b;
  end

  // Addressed status source drives its fixed pattern only while strobed
  always_comb
  begin
    inbound_data = noise;
    for (int i = 0; i < `FMS_IN_N; i++)
      if (inbound_formatter_strobe[i])
        inbound_data = 8'h70 + 8'(i);
  end

  // Status levels feed every test input; bits 0 and 1 are ignored inside
  assign jump_condition_input = status_level;
endmodule

// ### fms_params.svh
`ifndef FMS_PARAMS_SVH
`define FMS_PARAMS_SVH

// Widths and depths
`define FMS_PC_W        10
`define FMS_DB_W        8
`define FMS_RW_W        16
`define FMS_AB_W        4
`define FMS_IB_W        3
`define FMS_ROM_DEPTH   1024
`define FMS_SP_DEPTH    16
`define FMS_COND_N      16
`define FMS_OUT_N       16
`define FMS_IN_N        8

// Fields of the fetched word
`define FMS_OP_HI       15
`define FMS_OP_LO       12
`define FMS_IOSEL_BIT   11
`define FMS_ALU_HI      10
`define FMS_ALU_LO      8
`define FMS_CND_HI      13
`define FMS_CND_LO      10
`define FMS_XA_HI       9
`define FMS_XA_LO       8
`define FMS_LIT_HI      7
`define FMS_LIT_LO      0
`define FMS_ABSEL_BIT   13
`define FMS_ABL_HI      3
`define FMS_ABL_LO      0

// Fixed condition inputs
`define FMS_CND_TRUE    4'h0
`define FMS_CND_ZERO    4'h1

// Register port map
`define FMS_REG_A_W     3
`define FMS_REG_CTRL    3'h0
`define FMS_REG_ROMADR  3'h1
`define FMS_REG_ROMDAT  3'h2
`define FMS_REG_STATUS  3'h3
`define FMS_REG_ACC     3'h4
`define FMS_REG_RET     3'h5
`define FMS_RUN_BIT     0

// Reset values
`define FMS_PC_RST      10'h000
`define FMS_ACC_RST     8'h00
`define FMS_WORD_RST    16'h0000
`define FMS_CB_RST      8'h00
`define FMS_AB_RST      4'h0

`endif

// ### fms_pkg.sv
package fms_pkg;

  // ALU function codes
  typedef enum logic [2:0] {
    FMS_ALU_PASS = 3'h0,
    FMS_ALU_ADD  = 3'h1,
    FMS_ALU_SUB  = 3'h2,
    FMS_ALU_AND  = 3'h3,
    FMS_ALU_OR   = 3'h4,
    FMS_ALU_XOR  = 3'h5,
    FMS_ALU_HOLD = 3'h6,
    FMS_ALU_INC  = 3'h7
  } fms_alu_t;

  // Decoded internal micro-strobes
  typedef struct packed {
    logic inp;
    logic outp;
    logic mem;
    logic call;
    logic akb;
    logic ret;
    logic acc;
    logic jump;
  } fms_ustrb_t;

endpackage

// ### fms_sequencer.sv
// Notes on behaviour
// - One 8-bit shared data bus carries internal transfers; outbound data has its own register, fed from the next accumulator or the literal.
// - Jump addresses gain two control bits to reach 10 bits; returns take them from the return register.
// - Program counter steps by one each instruction and addresses the ROM.
// - Conditional jump target sits on data bus; taken only if condition true.
// - Both unconditional and tested jumps; counting resumes from the new address.
// - Call copies the already advanced counter into the return register.
// - Return loads the counter from the return register.
// - ROM word is buffered and split into control, data and address buses.
// - Control bits 12 to 15 decode into internal micro-strobes.
// - Control bits 8 to 10 select the ALU function.
// - Control bits 10 to 13 select the jump test input.
// - Bit 11 low steers I/O strobes outside; high steers them to scratch pad.
// - Formatter strobes come from demultiplexers gated by bit 11 and address bus.
// - Outbound strobe carries bus data out; inbound strobe fetches source data.
// - Address bus routes formatter strobes and selects the scratch-pad location.
// - ROM literals serve as control words, patterns, operands and timing values.
// - ALU combines accumulator and bus value, result back to accumulator.
// - Zero ALU result raises the zero flag, a selectable jump test input.
// - Scratch pad keeps temporary values and serves delay and count loops.
// - Address load is stretched a cycle; the following fetched word is dropped.
// - Return puts the return register on the bus, then address load takes it.
// - Counter is 10 bits, advances each clock, loads the bus on address load.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "fms_params.svh"

module fms_sequencer (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic [`FMS_REG_A_W-1:0]     reg_addr,
  input  wire logic [`FMS_RW_W-1:0]        reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [`FMS_RW_W-1:0]        reg_rdata,
  input  wire logic [`FMS_COND_N-1:0]      jump_condition_input,
  input  wire logic [`FMS_DB_W-1:0]        inbound_data,
  output logic      [`FMS_DB_W-1:0]        outbound_data,
  output logic      [`FMS_OUT_N-1:0]       outbound_formatter_strobe,
  output logic      [`FMS_IN_N-1:0]        inbound_formatter_strobe,
  output logic                             alu_zero_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Opcode decode, shared by the fetch and execute stages
  function automatic fms_pkg::fms_ustrb_t fms_decode(
    input logic [3:0] op
  );
    fms_pkg::fms_ustrb_t u;
    begin
      u = '0;
      casez (op)
        4'b0000:
        begin
          u.mem = 1'b1;
          u.acc = 1'b1;
        end
        4'b0001: u.ret = 1'b1;
        4'b001?:
        begin
          u.outp = 1'b1;
          u.akb  = 1'b1;
        end
        4'b0100:
        begin
          u.mem  = 1'b1;
          u.jump = 1'b1;
        end
        4'b0101:
        begin
          u.inp  = 1'b1;
          u.acc  = 1'b1;
          u.jump = 1'b1;
        end
        4'b011?:
        begin
          u.outp = 1'b1;
          u.mem  = 1'b1;
        end
        4'b10??:
        begin
          u.mem  = 1'b1;
          u.jump = 1'b1;
        end
        default:
        begin
          u.mem  = 1'b1;
          u.call = 1'b1;
          u.jump = 1'b1;
        end
      endcase
      fms_decode = u;
    end
  endfunction

  // Strobe address: upper field when bit 13 set, else low nibble
  function automatic logic [`FMS_AB_W-1:0] fms_abus(
    input logic [`FMS_RW_W-1:0] w
  );
    if (w[`FMS_ABSEL_BIT])
      fms_abus = {w[`FMS_ABSEL_BIT-1], w[`FMS_ALU_HI:`FMS_ALU_LO+1], w[`FMS_ALU_LO]};
    else
      fms_abus = w[`FMS_ABL_HI:`FMS_ABL_LO];
  endfunction

  // Accumulator ALU
  function automatic logic [`FMS_DB_W-1:0] fms_alu(
    input fms_pkg::fms_alu_t f,
    input logic [`FMS_DB_W-1:0] a,
    input logic [`FMS_DB_W-1:0] b
  );
    begin
      unique case (f)
        fms_pkg::FMS_ALU_PASS: fms_alu = b;
        fms_pkg::FMS_ALU_ADD:  fms_alu = a + b;
        fms_pkg::FMS_ALU_SUB:  fms_alu = a - b;
        fms_pkg::FMS_ALU_AND:  fms_alu = a & b;
        fms_pkg::FMS_ALU_OR:   fms_alu = a | b;
        fms_pkg::FMS_ALU_XOR:  fms_alu = a ^ b;
        fms_pkg::FMS_ALU_HOLD: fms_alu = a;
        fms_pkg::FMS_ALU_INC:  fms_alu = b + 8'h01;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [`FMS_RW_W-1:0]  rom [0:`FMS_ROM_DEPTH-1];
  logic [`FMS_DB_W-1:0]  scratch [0:`FMS_SP_DEPTH-1];
  logic [`FMS_PC_W-1:0]  pc;
  logic [`FMS_PC_W-1:0]  ret_addr;
  logic [`FMS_PC_W-1:0]  rom_wr_addr;
  logic [`FMS_DB_W-1:0]  control_field_bus;
  logic [`FMS_DB_W-1:0]  lit_buf;
  logic [`FMS_AB_W-1:0]  strobe_address_bus;
  logic                  buf_valid;
  logic                  address_load_strobe_stretch;
  logic                  run;
  logic [`FMS_DB_W-1:0]  accumulator_operand;
  // Combinational nets
  logic [`FMS_RW_W-1:0]  rom_output_word;
  fms_pkg::fms_ustrb_t   fetch_strobe;
  fms_pkg::fms_ustrb_t   internal_micro_strobe;
  logic                  fetch_ok;
  logic [`FMS_AB_W-1:0]  fetch_ab;
  logic                  fetch_io;
  logic [`FMS_DB_W-1:0]  shared_data_bus;
  logic [1:0]            addr_ext;
  logic [`FMS_PC_W-1:0]  jump_target;
  logic [`FMS_COND_N-1:0] cond_vec;
  logic                  io_or_scratch_select;
  logic [3:0]            condition_select_field;
  logic                  jump_yes;
  logic                  address_load_strobe;
  logic [`FMS_DB_W-1:0]  alu_result;
  logic [`FMS_DB_W-1:0]  next_acc;
  fms_pkg::fms_alu_t     alu_function_field;
  logic [3:0]            strobe_opcode_field;

  ////////////////////////////////////////////////////////////////////////////
  // Fetch stage

  // Asynchronous ROM read at the counter; the word enters the buffers next edge
  assign rom_output_word = rom[pc];
  assign fetch_ok        = run & ~address_load_strobe;
  assign fetch_strobe    = fms_decode(rom_output_word[`FMS_OP_HI:`FMS_OP_LO]);
  assign fetch_ab        = fms_abus(rom_output_word);
  assign fetch_io        = rom_output_word[`FMS_IOSEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Execute stage decode

  assign strobe_opcode_field    = control_field_bus[`FMS_OP_HI-8:`FMS_OP_LO-8];
  assign io_or_scratch_select   = control_field_bus[`FMS_IOSEL_BIT-8];
  assign condition_select_field = control_field_bus[`FMS_CND_HI-8:`FMS_CND_LO-8];
  assign alu_function_field     =
    fms_pkg::fms_alu_t'(control_field_bus[`FMS_ALU_HI-8:`FMS_ALU_LO-8]);

  // Strobes fire only from a valid word outside the stretch cycle
  assign internal_micro_strobe = (buf_valid && !address_load_strobe_stretch) ?
                                 fms_decode(strobe_opcode_field) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Shared data bus

  // One source at a time; idle bus reads as zero so nothing floats
  always_comb
  begin
    shared_data_bus = '0;
    if (internal_micro_strobe.mem)
      shared_data_bus = lit_buf;
    else if (internal_micro_strobe.ret)
      shared_data_bus = ret_addr[`FMS_DB_W-1:0];
    else if (internal_micro_strobe.akb)
      shared_data_bus = accumulator_operand;
    else if (internal_micro_strobe.inp && io_or_scratch_select)
      shared_data_bus = scratch[strobe_address_bus];
    else if (internal_micro_strobe.inp)
      shared_data_bus = inbound_data;
  end

  // Two extra address bits: control field for jumps, return register for returns
  assign addr_ext    = internal_micro_strobe.ret ?
                       ret_addr[`FMS_PC_W-1:`FMS_DB_W] :
                       control_field_bus[`FMS_XA_HI-8:`FMS_XA_LO-8];
  assign jump_target = {addr_ext, shared_data_bus};

  ////////////////////////////////////////////////////////////////////////////
  // Jump test

  // Index 0 is always true for outright jumps; index 1 is the zero flag
  always_comb
  begin
    cond_vec                = jump_condition_input;
    cond_vec[`FMS_CND_TRUE] = 1'b1;
    cond_vec[`FMS_CND_ZERO] = alu_zero_flag;
  end

  assign jump_yes            = internal_micro_strobe.jump & cond_vec[condition_select_field];
  assign address_load_strobe = jump_yes | internal_micro_strobe.ret;

  ////////////////////////////////////////////////////////////////////////////
  // ALU

  assign alu_result = fms_alu(alu_function_field, accumulator_operand, shared_data_bus);
  assign next_acc   = internal_micro_strobe.acc ? alu_result : accumulator_operand;

  // Accumulator and zero flag update together
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      accumulator_operand <= `FMS_ACC_RST;
      alu_zero_flag       <= 1'b0;
    end
    else if (internal_micro_strobe.acc)
    begin
      accumulator_operand <= alu_result;
      alu_zero_flag       <= (alu_result == `FMS_ACC_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  // Stopped sequencer parks at zero so a restart begins cleanly
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pc <= `FMS_PC_RST;
    else if (!run)
      pc <= `FMS_PC_RST;
    else if (address_load_strobe)
      pc <= jump_target;
    else
      pc <= pc + 10'h001;
  end

  // Return register; counter already holds the next address
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ret_addr <= `FMS_PC_RST;
    else if (internal_micro_strobe.call)
      ret_addr <= pc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ROM fan-out buffers

  // Word fetched during a load is marked invalid; this is the skipped step
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      control_field_bus  <= `FMS_CB_RST;
      lit_buf            <= `FMS_ACC_RST;
      strobe_address_bus <= `FMS_AB_RST;
      buf_valid          <= 1'b0;
    end
    else
    begin
      control_field_bus  <= rom_output_word[`FMS_OP_HI:`FMS_XA_LO];
      lit_buf            <= rom_output_word[`FMS_LIT_HI:`FMS_LIT_LO];
      strobe_address_bus <= fetch_ab;
      buf_valid          <= fetch_ok;
    end
  end

  // Load strobe held one more cycle to shadow the next instruction
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      address_load_strobe_stretch <= 1'b0;
    else
      address_load_strobe_stretch <= address_load_strobe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Formatter strobes

  // Decoded one stage early so the flops line up with the executing step
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      outbound_formatter_strobe <= '0;
      inbound_formatter_strobe  <= '0;
    end
    else
    begin
      outbound_formatter_strobe <= '0;
      inbound_formatter_strobe  <= '0;
      if (fetch_ok && fetch_strobe.outp && !fetch_io)
        outbound_formatter_strobe[fetch_ab] <= 1'b1;
      if (fetch_ok && fetch_strobe.inp && !fetch_io)
        inbound_formatter_strobe[fetch_ab[`FMS_IB_W-1:0]] <= 1'b1;
    end
  end

  // Outbound data: accumulator after this edge, or the literal
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      outbound_data <= `FMS_ACC_RST;
    else if (fetch_ok && fetch_strobe.outp && !fetch_io)
      outbound_data <= fetch_strobe.akb ? next_acc :
                       rom_output_word[`FMS_LIT_HI:`FMS_LIT_LO];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scratch pad

  // No reset on the array: contents are undefined until written
  always_ff @(posedge ref_clk)
  begin
    if (internal_micro_strobe.outp && io_or_scratch_select)
      scratch[strobe_address_bus] <= shared_data_bus;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  // Run control
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      run <= 1'b0;
    else if (reg_wr && reg_addr == `FMS_REG_CTRL)
      run <= reg_wdata[`FMS_RUN_BIT];
  end

  // Program load pointer, steps after each data write
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rom_wr_addr <= `FMS_PC_RST;
    else if (reg_wr && reg_addr == `FMS_REG_ROMADR)
      rom_wr_addr <= reg_wdata[`FMS_PC_W-1:0];
    else if (reg_wr && reg_addr == `FMS_REG_ROMDAT)
      rom_wr_addr <= rom_wr_addr + 10'h001;
  end

  // Program store; loading while running is allowed but unwise
  always_ff @(posedge ref_clk)
  begin
    if (reg_wr && reg_addr == `FMS_REG_ROMDAT)
      rom[rom_wr_addr] <= reg_wdata;
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else
    begin
      unique case (reg_addr)
        `FMS_REG_CTRL:   reg_rdata <= {15'h0000, run};
        `FMS_REG_ROMADR: reg_rdata <= {6'h00, rom_wr_addr};
        `FMS_REG_ROMDAT: reg_rdata <= rom[rom_wr_addr];
        `FMS_REG_STATUS: reg_rdata <= {4'h0, address_load_strobe_stretch, alu_zero_flag, pc};
        `FMS_REG_ACC:    reg_rdata <= {8'h00, accumulator_operand};
        `FMS_REG_RET:    reg_rdata <= {6'h00, ret_addr};
        default:         reg_rdata <= '0;
      endcase
    end
  end

endmodule

// ### fms_sequencer_assertions.sv
`timescale 1ns/1ns
`include "fms_params.svh"

module fms_sequencer_assertions (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic [`FMS_REG_A_W-1:0] reg_addr,
  input  wire logic [`FMS_RW_W-1:0]    reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic [`FMS_DB_W-1:0]    outbound_data,
  input  wire logic [`FMS_OUT_N-1:0]   outbound_formatter_strobe,
  input  wire logic [`FMS_IN_N-1:0]    inbound_formatter_strobe,
  input  wire logic                    alu_zero_flag
);
  logic ctl_wr;
  logic quiet;
  logic started;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  //////////////////////////////////////////////////////////////////////////////
  // Run control writes and an idle formatter side
  assign ctl_wr = reg_wr && reg_addr == `FMS_REG_CTRL;
  assign quiet  = outbound_formatter_strobe == '0 && inbound_formatter_strobe == '0;

  // Nothing may execute before software first sets run
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      started <= 1'b0;
    else if (ctl_wr && reg_wdata[`FMS_RUN_BIT])
      started <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  out_one_hot_a: assert property ($onehot0(outbound_formatter_strobe))
    else $error("outbound strobes overlap");
  in_one_hot_a: assert property ($onehot0(inbound_formatter_strobe))
    else $error("inbound strobes overlap");
  io_exclusive_a: assert property (!(|outbound_formatter_strobe && |inbound_formatter_strobe))
    else $error("inbound and outbound strobe together");
  out_data_hold_a: assert property (!(|outbound_formatter_strobe) |-> $stable(outbound_data))
    else $error("outbound data moved without a strobe");
  reset_clear_a: assert property ($fell(reset) |-> (quiet && !alu_zero_flag && outbound_data == '0) [*2])
    else $error("outputs not clear after reset");
  idle_quiet_a: assert property (!started |-> quiet)
    else $error("strobe before the program was started");
  zero_idle_a: assert property (!started |=> $stable(alu_zero_flag))
    else $error("zero flag moved with nothing executing");
  stop_quiet_a: assert property ((ctl_wr && !reg_wdata[`FMS_RUN_BIT]) ##1 (!ctl_wr) [*3] |=> quiet)
    else $error("strobe long after the program was stopped");

  cover property (|outbound_formatter_strobe);
  cover property (|inbound_formatter_strobe);
  cover property ($rose(alu_zero_flag));
endmodule

bind fms_sequencer fms_sequencer_assertions fms_sequencer_assertions_inst (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .outbound_data(outbound_data), .outbound_formatter_strobe(outbound_formatter_strobe),
  .inbound_formatter_strobe(inbound_formatter_strobe), .alu_zero_flag(alu_zero_flag)
);

// ### test_formatter_microsequencer.sv
`timescale 1ns/1ns
`include "fms_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

module test_formatter_microsequencer;
  typedef struct packed {logic [2:0] f; logic [7:0] a; logic [7:0] b; logic [7:0] r;} fms_row_t;

  logic                    ref_clk = 1'b0;
  logic                    reset = 1'b1;
  logic [`FMS_REG_A_W-1:0] reg_addr = '0;
  logic [`FMS_RW_W-1:0]    reg_wdata = '0;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic [`FMS_RW_W-1:0]    reg_rdata;
  logic [`FMS_COND_N-1:0]  jump_condition_input;
  logic [`FMS_COND_N-1:0]  status_level = 16'h0100;
  logic [`FMS_DB_W-1:0]    inbound_data;
  logic [`FMS_DB_W-1:0]    outbound_data;
  logic [`FMS_OUT_N-1:0]   outbound_formatter_strobe;
  logic [`FMS_IN_N-1:0]    inbound_formatter_strobe;
  logic                    alu_zero_flag;
  int                      num_errors = 0;
  int                      n_compared = 0;
  int                      cyc = 0;
  logic [15:0]             prog_q[$];
  logic [40:0]             log_q[$];
  logic [40:0]             exp_q[$];
  // ALU function, accumulator, bus operand, result
  fms_row_t                rows [8] = '{'{3'h0, 8'h11, 8'h5a, 8'h5a}, '{3'h1, 8'h7f, 8'h81, 8'h00},
                                        '{3'h2, 8'h10, 8'h11, 8'hff}, '{3'h3, 8'hf0, 8'h3c, 8'h30},
                                        '{3'h4, 8'hf0, 8'h0f, 8'hff}, '{3'h5, 8'haa, 8'hff, 8'h55},
                                        '{3'h6, 8'hc3, 8'h12, 8'hc3}, '{3'h7, 8'h00, 8'hff, 8'h00}};

  always #4 ref_clk = ~ref_clk;

  fms_sequencer fms_sequencer_inst (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .jump_condition_input(jump_condition_input),
    .inbound_data(inbound_data), .outbound_data(outbound_data), .alu_zero_flag(alu_zero_flag),
    .outbound_formatter_strobe(outbound_formatter_strobe), .inbound_formatter_strobe(inbound_formatter_strobe)
  );

  fms_formatter_model fms_formatter_model_inst (
    .ref_clk(ref_clk), .reset(reset), .outbound_formatter_strobe(outbound_formatter_strobe),
    .inbound_formatter_strobe(inbound_formatter_strobe), .outbound_data(outbound_data),
    .status_level(status_level), .inbound_data(inbound_data), .jump_condition_input(jump_condition_input)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Every outbound step is logged with its cycle, so spacing shows jumps and drops
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (|outbound_formatter_strobe)
      log_q.push_back({cyc[15:0], outbound_formatter_strobe, outbound_data, alu_zero_flag});
  end

  task automatic end_sim();
    $display("Errors: %0d  Compared: %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A gap after each strobe keeps every assignment to a strobe in its own step
  task automatic wr(input logic [`FMS_REG_A_W-1:0] a, input logic [`FMS_RW_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [`FMS_REG_A_W-1:0] a, input logic [`FMS_RW_W-1:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge ref_clk);
  endtask

  // Order, values and cycle spacing of the logged steps
  task automatic cmp_log();
    `CHK(log_q.size(), exp_q.size())
    foreach (exp_q[i])
      if (i < log_q.size())
      begin
        `CHK(log_q[i][24:0], exp_q[i][24:0])
        if (i > 0)
          `CHK(16'(log_q[i][40:25] - log_q[i-1][40:25]), exp_q[i][40:25])
      end
  endtask

  // No completion signal exists, so the program gets a fixed span then is stopped
  task automatic run_prog();
    wr(`FMS_REG_ROMADR, 16'h0000);
    foreach (prog_q[i])
      wr(`FMS_REG_ROMDAT, prog_q[i]);
    log_q.delete();
    wr(`FMS_REG_CTRL, 16'h0001);
    repeat (60) @(posedge ref_clk);
    wr(`FMS_REG_CTRL, 16'h0000);
    cmp_log();
    prog_q.delete();
    exp_q.delete();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    `CHK({outbound_formatter_strobe, inbound_formatter_strobe, outbound_data, alu_zero_flag}, 33'h0)
    wr(3'h6, 16'hffff);
    rd(3'h6, 16'h0000);
    rd(`FMS_REG_STATUS, 16'h0000);
    // Each row: load accumulator, apply the function, send the accumulator out
    foreach (rows[i])
    begin
      prog_q.push_back({8'h00, rows[i].a});
      prog_q.push_back({5'h00, rows[i].f, rows[i].b});
      prog_q.push_back(16'h2000 + 16'(i << 8));
      exp_q.push_back({16'd3, 16'(1 << i), rows[i].r, rows[i].r == 8'h00});
    end
    prog_q.push_back(16'h8018);
    prog_q.push_back(16'h0000);
    run_prog();
    // Reset in mid-run clears the strobes, outbound data and zero flag, and nothing moves afterwards
    wr(`FMS_REG_CTRL, 16'h0001);
    repeat (6) @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK({outbound_formatter_strobe, inbound_formatter_strobe, outbound_data, alu_zero_flag}, 33'h0)
    @(posedge ref_clk);
    reset <= 1'b0;
    log_q.delete();
    repeat (20) @(posedge ref_clk);
    `CHK(log_q.size(), 0)
    // Call, scratch round trip, inbound compare, untaken and taken tests, return
    prog_q = '{16'h72a5, 16'hc005, 16'h733c, 16'h8003, 16'h0000, 16'h6b72, 16'h5803, 16'h2600,
               16'h5202, 16'h480e, 16'h440e, 16'h720f, 16'h72ee, 16'h72ee, 16'h1000, 16'h72dd};
    exp_q = '{{16'd0, 16'h0400, 8'ha5, 1'b0}, {16'd5, 16'h0040, 8'h72, 1'b0}, {16'd7, 16'h0800, 8'h3c, 1'b1}};
    run_prog();
    `CHK(fms_formatter_model_inst.ctl_reg[6], 8'h72)
    `CHK(fms_formatter_model_inst.ctl_reg[11], 8'h3c)
    `CHK(alu_zero_flag, 1'b1)
    rd(`FMS_REG_ACC, 16'h0000);
    rd(`FMS_REG_RET, 16'h0002);
    end_sim();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
endmodule
